// File: inc/dam_pkg.sv
// constants of the ds1 receive alarm monitor
package dam_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_BLKEN = 8'h01;
  localparam logic [7:0] IDX_STAT  = 8'h02;
  localparam logic [7:0] IDX_AEEN  = 8'h03;
  localparam logic [7:0] IDX_CTRL  = 8'h04;
  // field positions
  localparam int unsigned BLK_AE_BIT   = 1;
  localparam int unsigned EN_AIS_BIT   = 1;
  localparam int unsigned EN_RED_BIT   = 2;
  localparam int unsigned ST_AISC_BIT  = 1;
  localparam int unsigned ST_REDC_BIT  = 2;
  localparam int unsigned ST_AIS_BIT   = 6;
  localparam int unsigned ST_RED_BIT   = 7;
  localparam int unsigned CTRL_RUR_BIT = 0;
  localparam logic [7:0]  REG_RST      = 8'h00;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // alarm integration
  localparam int unsigned RED_W      = 6;
  localparam logic [5:0]  RED_THR    = 6'h3F;
  localparam int unsigned AIS_W      = 8;
  localparam logic [7:0]  AIS_THR    = 8'hFF;
  localparam logic [4:0]  AIS_NEED   = 5'h16;
  localparam logic [4:0]  AIS_CNTMAX = 5'h1F;
  // interval timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned INTERVAL_MS   = 6;
  localparam int unsigned INTERVAL_CYC  = INTERVAL_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned IVL_W         = 19;
endpackage

// File: inc/dam_flag_if.sv
// interval flag and alarm state between monitor and integrator
`timescale 1ns/1ps
interface dam_flag_if;
  logic tick;
  logic flag;
  logic state;
  logic chg;
  modport src (output tick, output flag, input state, input chg);
  modport itg (input tick, input flag, output state, output chg);
endinterface

// File: verilog/dam_interval.sv
// free running interval timer, one tick per interval
`timescale 1ns/1ps
module dam_interval #(
  parameter int unsigned CYC = dam_pkg::INTERVAL_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);
  typedef struct packed {
    logic [dam_pkg::IVL_W-1:0] cnt;
    logic                      tick;
  } dam_ivl_t;

  localparam logic [dam_pkg::IVL_W-1:0] LAST = (dam_pkg::IVL_W)'(CYC - 1);

  dam_ivl_t q;
  dam_ivl_t d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == LAST) begin
      d.cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule

// File: verilog/dam_integrator.sv
// up/down flag counter that declares and removes one alarm
`timescale 1ns/1ps
module dam_integrator #(
  parameter int unsigned W   = 8,
  parameter logic [W-1:0] THR = '1
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  dam_flag_if.itg   f
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         state;
    logic         chg;
  } dam_itg_t;

  dam_itg_t q;
  dam_itg_t d;

  always_comb begin
    d = q;
    d.chg = 1'b0;
    if (f.tick) begin
      if (f.flag && q.cnt != THR) begin
        d.cnt = q.cnt + 1'b1;
      end else if (!f.flag && q.cnt != '0) begin
        d.cnt = q.cnt - 1'b1;
      end
      // hysteresis: declared at the top, removed only at zero
      if (d.cnt == THR && !q.state) begin
        d.state = 1'b1;
        d.chg = 1'b1;
      end else if (d.cnt == '0 && q.state) begin
        d.state = 1'b0;
        d.chg = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign f.state = q.state;
  assign f.chg = q.chg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_itg_declare: assert property (
    (f.tick && f.flag && q.cnt == THR - 1'b1 && !q.state) |=> (q.state && q.chg))
    else $error("alarm not declared at threshold");
  a_itg_remove: assert property (
    (f.tick && !f.flag && q.cnt == 1'b1 && q.state) |=> (!q.state && q.chg))
    else $error("alarm not removed at zero");
  a_itg_chg_only: assert property (
    !f.tick |=> ($stable(q.state) && !q.chg))
    else $error("alarm state moved between intervals");
endmodule

// File: verilog/dam_monitor.sv
// ds1 receive ais and red alarm monitor with axi4-lite registers
// Contract
// - alarm enable register bit 1 permits the ais change interrupt
// - block enable register bit 1 gates every alarm interrupt
// - status bit 6 reads one while ais is declared
// - any ais state change sets sticky status bit 1
// - with reset-upon-read, a status read clears change bits and interrupt
// - change bits stay set until software clears them
// - time runs in 6 ms intervals; any frame loss flags the interval
// - each flagged interval counts up; red alarm declared at 63
// - each unflagged interval counts down; red alarm removed at zero
// - alarm enable bit 2 permits the red change and frame loss interrupt
// - red state bit reads one while red alarm is declared
// - a red state change sets the sticky red change bit
// - interval flags ais when at least 22 detections occur in it
// - ais counter counts up to 255 to declare, down to zero to remove
// - red change bit sits at status bit 2, cleared by a write of one or by a status read with reset-upon-read
// - red state bit sits at status bit 7
`timescale 1ns/1ps
module dam_monitor #(
  parameter int unsigned INTERVAL_CYC = dam_pkg::INTERVAL_CYC
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [dam_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [dam_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [dam_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [dam_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        frame_loss,
  input  wire logic                        ais_detect,
  output logic                             ais_alarm,
  output logic                             red_alarm,
  output logic                             irq,
  output logic                             rx_frame_loss_irq
);
  typedef struct packed {
    logic       lof_s1;
    logic       lof_s2;
    logic       ais_s1;
    logic       ais_s2;
    logic       ais_s3;
    logic       lof_seen;
    logic [4:0] ais_cnt;
    logic       blk_en;
    logic       en_ais;
    logic       en_red;
    logic       rur;
    logic       st_ais;
    logic       st_red;
    logic       irq;
    logic       lof_irq;
    logic       aw_got;
    logic [7:0] awaddr;
    logic       w_got;
    logic [7:0] wdata;
    logic       wstrb0;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } dam_state_t;

  dam_state_t q;
  dam_state_t d;

  logic       tick;
  logic       lof_now;
  logic [4:0] ais_tot;
  logic       ais_edge;
  logic       wr_go;
  logic       rd_go;

  dam_flag_if ais_f ();
  dam_flag_if red_f ();

  dam_interval #(
    .CYC (INTERVAL_CYC)
  ) u_interval (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  dam_integrator #(
    .W   (dam_pkg::AIS_W),
    .THR (dam_pkg::AIS_THR)
  ) u_ais (
    .aclk    (aclk),
    .aresetn (aresetn),
    .f       (ais_f.itg)
  );

  dam_integrator #(
    .W   (dam_pkg::RED_W),
    .THR (dam_pkg::RED_THR)
  ) u_red (
    .aclk    (aclk),
    .aresetn (aresetn),
    .f       (red_f.itg)
  );

  // one-hot register select: block enable, status, alarm enable, control
  function automatic logic [3:0] reg_sel(input logic [7:0] addr);
    logic [7:0] idx;
    idx = {2'h0, addr[7:2]};
    reg_sel = {idx == dam_pkg::IDX_CTRL, idx == dam_pkg::IDX_AEEN,
               idx == dam_pkg::IDX_STAT, idx == dam_pkg::IDX_BLKEN};
  endfunction

  // the event of the current cycle still belongs to the ending interval
  assign ais_edge = q.ais_s2 & ~q.ais_s3;
  assign lof_now = q.lof_seen | q.lof_s2;
  assign ais_tot = (q.ais_cnt == dam_pkg::AIS_CNTMAX) ? q.ais_cnt
                   : q.ais_cnt + {4'h0, ais_edge};

  assign red_f.tick = tick;
  assign red_f.flag = lof_now;
  assign ais_f.tick = tick;
  assign ais_f.flag = (ais_tot >= dam_pkg::AIS_NEED);

  assign wr_go = q.aw_got & q.w_got & ~q.bvalid;
  assign rd_go = q.arready & s_axi_arvalid;

  always_comb begin
    logic [3:0] wsel;
    logic [3:0] rsel;
    logic [7:0] stat;
    logic       clr_ais;
    logic       clr_red;
    wsel = reg_sel(q.awaddr);
    rsel = reg_sel(s_axi_araddr);
    stat = dam_pkg::REG_RST;
    clr_ais = 1'b0;
    clr_red = 1'b0;
    d = q;

    // two-flop synchronisers; the second stage is read, and ais_s3 too for the ais edge
    d.lof_s1 = frame_loss;
    d.lof_s2 = q.lof_s1;
    d.ais_s1 = ais_detect;
    d.ais_s2 = q.ais_s1;
    d.ais_s3 = q.ais_s2;

    if (tick) begin
      d.lof_seen = 1'b0;
      d.ais_cnt = '0;
    end else begin
      d.lof_seen = lof_now;
      d.ais_cnt = ais_tot;
    end

    stat[dam_pkg::ST_AIS_BIT] = ais_f.state;
    stat[dam_pkg::ST_RED_BIT] = red_f.state;
    stat[dam_pkg::ST_AISC_BIT] = q.st_ais;
    stat[dam_pkg::ST_REDC_BIT] = q.st_red;

    // write channel: address and data taken in either order
    if (q.awready && s_axi_awvalid) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (q.wready && s_axi_wvalid) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata[7:0];
      d.wstrb0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_go) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (wsel == 4'h0) ? dam_pkg::RESP_DECERR : dam_pkg::RESP_OKAY;
      if (q.wstrb0) begin
        if (wsel[0]) begin
          d.blk_en = q.wdata[dam_pkg::BLK_AE_BIT];
        end
        if (wsel[2]) begin
          d.en_ais = q.wdata[dam_pkg::EN_AIS_BIT];
          d.en_red = q.wdata[dam_pkg::EN_RED_BIT];
        end
        if (wsel[3]) begin
          d.rur = q.wdata[dam_pkg::CTRL_RUR_BIT];
        end
        if (wsel[1]) begin
          clr_ais = q.wdata[dam_pkg::ST_AISC_BIT];
          clr_red = q.wdata[dam_pkg::ST_REDC_BIT];
        end
      end
    end
    d.awready = ~d.aw_got;
    d.wready = ~d.w_got;

    // read channel
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rresp = (rsel == 4'h0) ? dam_pkg::RESP_DECERR : dam_pkg::RESP_OKAY;
      d.rdata = 8'h00;
      if (rsel[0]) begin
        d.rdata[dam_pkg::BLK_AE_BIT] = q.blk_en;
      end
      if (rsel[1]) begin
        d.rdata = stat;
        if (q.rur) begin
          clr_ais = 1'b1;
          clr_red = 1'b1;
        end
      end
      if (rsel[2]) begin
        d.rdata[dam_pkg::EN_AIS_BIT] = q.en_ais;
        d.rdata[dam_pkg::EN_RED_BIT] = q.en_red;
      end
      if (rsel[3]) begin
        d.rdata[dam_pkg::CTRL_RUR_BIT] = q.rur;
      end
    end
    d.arready = ~d.rvalid;

    // set beats clear so a change in the clearing cycle is kept
    d.st_ais = (q.st_ais & ~clr_ais) | ais_f.chg;
    d.st_red = (q.st_red & ~clr_red) | red_f.chg;

    d.irq = q.blk_en & ((d.st_ais & q.en_ais) | (d.st_red & q.en_red));
    d.lof_irq = q.blk_en & d.st_red & q.en_red;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = {24'h000000, q.rdata};
  assign ais_alarm = ais_f.state;
  assign red_alarm = red_f.state;
  assign irq = q.irq;
  assign rx_frame_loss_irq = q.lof_irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic rd_stat;
  assign rd_stat = rd_go && reg_sel(s_axi_araddr) == 4'h2;

  a_block_gate: assert property (
    !q.blk_en |=> !irq ##0 !rx_frame_loss_irq)
    else $error("interrupt passed with block enable low");
  a_irq_raise: assert property (
    (q.blk_en && q.en_ais && q.st_ais && $stable(q.blk_en) && !rd_go && !wr_go)
      |=> irq)
    else $error("enabled ais change did not raise interrupt");
  a_ais_read: assert property (
    rd_stat |=> (s_axi_rvalid && s_axi_rdata[6] == $past(ais_f.state)))
    else $error("ais state bit wrong on read");
  a_red_read: assert property (
    rd_stat |=> (s_axi_rdata[7] == $past(red_f.state) && s_axi_rdata[2] == $past(q.st_red)))
    else $error("red bits wrong on read");
  a_ais_sticky: assert property (
    ais_f.chg |=> q.st_ais)
    else $error("ais change not latched");
  a_red_sticky: assert property (
    red_f.chg |=> q.st_red)
    else $error("red change not latched");
  a_rur_clear: assert property (
    (rd_stat && q.rur && !ais_f.chg && !red_f.chg) |=> (!q.st_ais && !q.st_red))
    else $error("reset-upon-read left change bits set");
  a_sticky_hold: assert property (
    (q.st_red && !rd_go && !wr_go) |=> q.st_red)
    else $error("red change bit dropped without clear");
  a_lof_flag: assert property (
    (tick && q.lof_s2) |-> red_f.flag)
    else $error("frame loss missed in interval");
  a_ais_flag: assert property (
    (!tick && ais_edge && q.ais_cnt != dam_pkg::AIS_CNTMAX)
      |=> (q.ais_cnt == $past(q.ais_cnt) + 5'h01))
    else $error("ais detection not counted");
  a_red_enable: assert property (
    (!q.en_red && $stable(q.en_red)) |=> !rx_frame_loss_irq)
    else $error("frame loss interrupt with enable low");

  c_irq_rise: cover property ($rose(irq));
  c_red_decl: cover property ($rose(red_alarm));
  c_ais_decl: cover property ($rose(ais_alarm));
  c_rur_read: cover property (rd_stat && q.rur && q.st_red);
endmodule

// File: verification/dam_framer_model.sv
// receive framer model: loss-of-frame level and ais detection pulses
`timescale 1ns/1ps
module dam_framer_model (
  input  wire logic aclk,
  input  wire logic lof_on,
  input  wire logic ais_on,
  output logic      frame_loss,
  output logic      ais_detect
);
  logic [1:0] ph_q = 2'h0;
  initial frame_loss = 1'h0;
  initial ais_detect = 1'h0;
  always @(posedge aclk) begin
    ph_q       <= ph_q + 2'h1;
    frame_loss <= lof_on;
    // two high, two low: minimum width kept, 25 detections per 100 cycles
    ais_detect <= ais_on & ph_q[1];
  end
endmodule

// File: verification/tb_top.sv
// self-checking bench for the ds1 alarm monitor
`timescale 1ns/1ps
module tb_top;
  // short interval keeps the 255-interval ais run affordable
  localparam int unsigned IV = 100;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        lof_on = 1'h0;
  logic        ais_on = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, frame_loss, ais_detect;
  logic        ais_alarm, red_alarm, irq, lof_irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] e;
  logic [33:0] exp_q[$];
  logic [7:0]  r;
  int          n_fail = 0;
  int          num_checks = 0;

  always #10 aclk = ~aclk;

  dam_monitor #(.INTERVAL_CYC(IV)) dam_monitor_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .frame_loss(frame_loss), .ais_detect(ais_detect), .ais_alarm(ais_alarm),
    .red_alarm(red_alarm), .irq(irq), .rx_frame_loss_irq(lof_irq));

  dam_framer_model dam_framer_model_i (
    .aclk(aclk), .lof_on(lof_on), .ais_on(ais_on),
    .frame_loss(frame_loss), .ais_detect(ais_detect));

  task automatic chk(input logic [33:0] g, input logic [33:0] x);
    num_checks++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  // each channel held until its own ready; the response is noted first
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF,
                    input logic [1:0] x = dam_pkg::RESP_OKAY);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    exp_q.push_back({x, 32'h0});
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        w_done = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] x = dam_pkg::RESP_OKAY);
    exp_q.push_back({x, 24'h000000, d});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'h0;
  endtask

  // responses are matched in order against the notes of the driver
  always @(posedge aclk) begin
    if (bvalid && bready) begin
      e = exp_q.pop_front();
      chk({bresp, 32'h0}, e);
    end
    if (rvalid && rready) begin
      e = exp_q.pop_front();
      chk({rresp, rdata}, e);
    end
  end

  initial begin
    repeat (80000) @(posedge aclk);
    n_fail++;
    give_verdict;
  end

  // byte map: 04 block enable, 08 status, 0C alarm enable, 10 irq control
  initial begin
    r = 8'($urandom(38854));
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h14, 8'h00, dam_pkg::RESP_DECERR);
    wr(8'h40, 8'hFF, 4'hF, dam_pkg::RESP_DECERR);
    for (int i = 0; i < 4; i++) begin
      r = 8'($urandom);
      wr(8'h04, r);
      rd(8'h04, r & 8'h02);
      wr(8'h0C, r);
      rd(8'h0C, r & 8'h06);
      wr(8'h10, r);
      rd(8'h10, r & 8'h01);
      wr(8'h08, r);
      rd(8'h08, 8'h00);
    end
    wr(8'h04, 8'h00, 4'h0);
    rd(8'h04, r & 8'h02);
    wr(8'h10, 8'h00);
    wr(8'h04, 8'h02);
    wr(8'h0C, 8'h04);
    lof_on <= 1'h1;
    // first interval may be partial, hence the one-interval margins
    wt(61 * IV);
    chk(red_alarm, 34'h0);
    wt(3 * IV);
    chk(red_alarm, 34'h1);
    chk(irq, 34'h1);
    chk(lof_irq, 34'h1);
    rd(8'h08, 8'h84);
    rd(8'h08, 8'h84);
    wr(8'h04, 8'h00);
    wt(2);
    chk(irq, 34'h0);
    wr(8'h04, 8'h02);
    wr(8'h0C, 8'h00);
    wt(2);
    chk(lof_irq, 34'h0);
    chk(irq, 34'h0);
    wr(8'h0C, 8'h04);
    wr(8'h08, 8'h04);
    rd(8'h08, 8'h80);
    wt(2);
    chk(irq, 34'h0);
    wr(8'h10, 8'h01);
    lof_on <= 1'h0;
    wt(61 * IV);
    chk(red_alarm, 34'h1);
    // the interval holding the last frame loss is still flagged and holds the count at 63
    wt(5 * IV);
    chk(red_alarm, 34'h0);
    chk(irq, 34'h1);
    rd(8'h08, 8'h04);
    rd(8'h08, 8'h00);
    wt(2);
    chk(irq, 34'h0);
    wr(8'h0C, 8'h02);
    ais_on <= 1'h1;
    wt(253 * IV);
    chk(ais_alarm, 34'h0);
    wt(4 * IV);
    chk(ais_alarm, 34'h1);
    chk(irq, 34'h1);
    chk(lof_irq, 34'h0);
    rd(8'h08, 8'h42);
    ais_on <= 1'h0;
    wt(253 * IV);
    chk(ais_alarm, 34'h1);
    wt(4 * IV);
    chk(ais_alarm, 34'h0);
    rd(8'h08, 8'h02);
    // mid-run reset with enables and reset-upon-read still set
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h04, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h08, 8'h00);
    wt(2);
    chk(irq, 34'h0);
    chk(ais_alarm, 34'h0);
    give_verdict;
  end
endmodule
